/* hw/amst_pkg.sv */
// Package: constants, states and carrier types for the async memory strobe engine
package amst_pkg;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 21;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int CS_W = 4;
  localparam int WCNT_W = 8;
  localparam int SUB_W = 4;
  // Clock rate and the pin-to-strobe delay after the wait input drops
  localparam int CLK_MHZ = 100;
  localparam int WAIT_RELEASE_NS = 40;
  localparam int WAIT_RELEASE_CYC = (WAIT_RELEASE_NS * CLK_MHZ) / 1000;
  localparam int SYNC_STAGES = 2;
  localparam logic [CNT_W-1:0] TAIL_LEN = CNT_W'(WAIT_RELEASE_CYC - SYNC_STAGES);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [SUB_W-1:0] SUB_LAST = 4'hF;
  localparam logic [SUB_W-1:0] SUB_ZERO = 4'h0;
  localparam logic [WCNT_W-1:0] WCNT_ZERO = 8'h00;
  localparam logic [WCNT_W-1:0] WCNT_ONE = 8'h01;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_STROBE = 7'b0000100,
    ST_WAITX = 7'b0001000,
    ST_TAIL = 7'b0010000,
    ST_HOLD = 7'b0100000,
    ST_TURN = 7'b1000000
  } amst_state_e;

  // Programmed timing values
  typedef struct packed {
    logic [CNT_W-1:0] turnaround_cycles;
    logic [CNT_W-1:0] read_setup_cycles;
    logic [CNT_W-1:0] read_strobe_cycles;
    logic [CNT_W-1:0] read_hold_cycles;
    logic [CNT_W-1:0] write_setup_cycles;
    logic [CNT_W-1:0] write_strobe_cycles;
    logic [CNT_W-1:0] write_hold_cycles;
    logic [WCNT_W-1:0] max_ext_wait_cycles;
    logic extended_wait_enable;
    logic select_strobe;
  } amst_cfg_s;

  // One access request
  typedef struct packed {
    logic write;
    logic [CS_W-1:0] chip;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amst_req_s;
endpackage : amst_pkg

/* hw/amst_engine.sv */
// Async memory strobe timing engine: setup, strobe, wait, hold and turnaround
`timescale 1ns/10ps
`default_nettype none
module amst_engine (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire amst_pkg::amst_cfg_s CFG_I,
  input wire logic REQ_VALID_I,
  input wire amst_pkg::amst_req_s REQ_I,
  input wire logic EXT_WAIT_INPUT_I,
  input wire logic [amst_pkg::DATA_W-1:0] EXT_DATA_LINES_I,
  output logic [amst_pkg::CS_W-1:0] MEMORY_CHIP_SELECT_N_O,
  output logic ASYNC_WRITE_ENABLE_N_O,
  output logic ASYNC_OUTPUT_ENABLE_N_O,
  output logic [amst_pkg::BANK_W-1:0] BANK_SELECT_LINES_O,
  output logic [amst_pkg::ADDR_W-1:0] EXT_ADDR_LINES_O,
  output logic [amst_pkg::DATA_W-1:0] EXT_DATA_LINES_O,
  output logic EXT_DATA_OE_N_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic TIMEOUT_O,
  output logic [amst_pkg::DATA_W-1:0] RDATA_O,
  output logic [amst_pkg::WCNT_W-1:0] EXT_WAIT_COUNT_O
);
  typedef struct packed {
    amst_pkg::amst_state_e st;
    logic [amst_pkg::CNT_W-1:0] cnt;
    logic [amst_pkg::SUB_W-1:0] sub;
    logic [amst_pkg::WCNT_W-1:0] wcnt;
    logic wait_meta;
    logic wait_s;
    amst_pkg::amst_req_s req;
    logic [amst_pkg::CS_W-1:0] cs_n;
    logic we_n;
    logic oe_n;
    logic d_oe_n;
    logic busy;
    logic done;
    logic timeout;
    logic [amst_pkg::DATA_W-1:0] rdata;
  } amst_core_s;

  amst_core_s s_q;
  amst_core_s s_d;
  logic [amst_pkg::CNT_W-1:0] setup_len;
  logic [amst_pkg::CNT_W-1:0] strobe_len;
  logic [amst_pkg::CNT_W-1:0] hold_len;
  logic end_strobe;
  logic finish;

  // Phase lengths chosen by direction of the access
  assign setup_len = s_q.req.write ? CFG_I.write_setup_cycles : CFG_I.read_setup_cycles;
  assign strobe_len = s_q.req.write ? CFG_I.write_strobe_cycles : CFG_I.read_strobe_cycles;
  assign hold_len = s_q.req.write ? CFG_I.write_hold_cycles : CFG_I.read_hold_cycles;

  // Next state of the whole engine
  always_comb
  begin
    s_d = s_q;
    end_strobe = 1'b0;
    finish = 1'b0;
    s_d.done = 1'b0;
    s_d.timeout = 1'b0;
    s_d.wait_meta = EXT_WAIT_INPUT_I;
    s_d.wait_s = s_q.wait_meta;
    s_d.cnt = s_q.cnt + amst_pkg::CNT_ONE;
    unique case (s_q.st)
      amst_pkg::ST_IDLE:
      begin
        if (REQ_VALID_I)
        begin
          s_d.req = REQ_I;
          s_d.cnt = amst_pkg::CNT_ONE;
          s_d.wcnt = amst_pkg::WCNT_ZERO;
          s_d.sub = amst_pkg::SUB_ZERO;
          if ((REQ_I.write ? CFG_I.write_setup_cycles : CFG_I.read_setup_cycles)
              != amst_pkg::CNT_ZERO)
            s_d.st = amst_pkg::ST_SETUP;
          else
            s_d.st = amst_pkg::ST_STROBE;
        end
      end
      amst_pkg::ST_SETUP:
      begin
        // Setup phase in whole clocks
        if (s_q.cnt >= setup_len)
        begin
          s_d.st = amst_pkg::ST_STROBE;
          s_d.cnt = amst_pkg::CNT_ONE;
        end
      end
      amst_pkg::ST_STROBE:
      begin
        if (CFG_I.extended_wait_enable && s_q.wait_s)
          s_d.st = amst_pkg::ST_WAITX;
        else if (s_q.cnt >= strobe_len)
          end_strobe = 1'b1;
      end
      amst_pkg::ST_WAITX:
      begin
        // Each sixteen waited clocks add one wait count
        s_d.sub = s_q.sub + 4'h1;
        if (!s_q.wait_s)
        begin
          s_d.st = amst_pkg::ST_TAIL;
          s_d.cnt = amst_pkg::CNT_ONE;
          s_d.sub = s_q.sub;
        end
        else if (s_q.sub == amst_pkg::SUB_LAST)
        begin
          s_d.wcnt = s_q.wcnt + amst_pkg::WCNT_ONE;
          if (s_d.wcnt >= CFG_I.max_ext_wait_cycles)
          begin
            s_d.timeout = 1'b1;
            end_strobe = 1'b1;
          end
        end
      end
      amst_pkg::ST_TAIL:
      begin
        if (s_q.cnt >= amst_pkg::TAIL_LEN)
          end_strobe = 1'b1;
      end
      amst_pkg::ST_HOLD:
      begin
        if (s_q.cnt >= hold_len)
          finish = 1'b1;
      end
      amst_pkg::ST_TURN:
      begin
        if (s_q.cnt >= CFG_I.turnaround_cycles)
          s_d.st = amst_pkg::ST_IDLE;
      end
    endcase
    // Strobe end: capture read data, then hold or finish
    if (end_strobe)
    begin
      if (!s_q.req.write)
        s_d.rdata = EXT_DATA_LINES_I;
      s_d.cnt = amst_pkg::CNT_ONE;
      if (hold_len != amst_pkg::CNT_ZERO)
        s_d.st = amst_pkg::ST_HOLD;
      else
        finish = 1'b1;
    end
    if (finish)
    begin
      s_d.done = 1'b1;
      s_d.cnt = amst_pkg::CNT_ONE;
      s_d.st = (CFG_I.turnaround_cycles != amst_pkg::CNT_ZERO) ? amst_pkg::ST_TURN
                                                              : amst_pkg::ST_IDLE;
    end
    // Pin levels follow the next phase so they leave flops
    s_d.busy = (s_d.st != amst_pkg::ST_IDLE);
    s_d.we_n = 1'b1;
    s_d.oe_n = 1'b1;
    s_d.cs_n = {amst_pkg::CS_W{1'b1}};
    s_d.d_oe_n = 1'b1;
    if (s_d.st inside {amst_pkg::ST_STROBE, amst_pkg::ST_WAITX, amst_pkg::ST_TAIL})
    begin
      s_d.we_n = !s_d.req.write;
      s_d.oe_n = s_d.req.write;
      s_d.cs_n = ~s_d.req.chip;
    end
    if (s_d.st inside {amst_pkg::ST_SETUP, amst_pkg::ST_HOLD})
    begin
      if (!CFG_I.select_strobe)
        s_d.cs_n = ~s_d.req.chip;
    end
    if (s_d.st inside {amst_pkg::ST_SETUP, amst_pkg::ST_STROBE, amst_pkg::ST_WAITX,
                       amst_pkg::ST_TAIL, amst_pkg::ST_HOLD})
      s_d.d_oe_n = !s_d.req.write;
  end

  // State register
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_q <= '0;
      s_q.st <= amst_pkg::ST_IDLE;
      s_q.cs_n <= {amst_pkg::CS_W{1'b1}};
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.d_oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Pins straight from the state register; bank/address held from latch
  assign MEMORY_CHIP_SELECT_N_O = s_q.cs_n;
  assign ASYNC_WRITE_ENABLE_N_O = s_q.we_n;
  assign ASYNC_OUTPUT_ENABLE_N_O = s_q.oe_n;
  assign BANK_SELECT_LINES_O = s_q.req.bank;
  assign EXT_ADDR_LINES_O = s_q.req.addr;
  assign EXT_DATA_LINES_O = s_q.req.wdata;
  assign EXT_DATA_OE_N_O = s_q.d_oe_n;
  assign BUSY_O = s_q.busy;
  assign DONE_O = s_q.done;
  assign TIMEOUT_O = s_q.timeout;
  assign RDATA_O = s_q.rdata;
  assign EXT_WAIT_COUNT_O = s_q.wcnt;

  // Helper counts of chip select lead and strobe width
  logic [amst_pkg::CNT_W-1:0] lead_q;
  logic [amst_pkg::CNT_W-1:0] width_q;
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lead_q <= amst_pkg::CNT_ZERO;
      width_q <= amst_pkg::CNT_ZERO;
    end
    else
    begin
      lead_q <= (&s_q.cs_n || !s_q.we_n) ? amst_pkg::CNT_ZERO : lead_q + amst_pkg::CNT_ONE;
      width_q <= (s_q.we_n && s_q.oe_n) ? amst_pkg::CNT_ZERO : width_q + amst_pkg::CNT_ONE;
    end
  end

  a_cs_lead_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $fell(s_q.we_n) && !CFG_I.select_strobe |-> lead_q == CFG_I.write_setup_cycles)
    else $error("chip select lead before write strobe wrong");
  a_ss_fall_together: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $fell(s_q.we_n) && CFG_I.select_strobe |-> $past(&s_q.cs_n))
    else $error("chip select did not fall with write strobe");
  a_cs_hold_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(s_q.we_n) && !CFG_I.select_strobe && CFG_I.write_hold_cycles != 8'h00
    |-> !(&s_q.cs_n))
    else $error("chip select rose with write strobe despite hold");
  a_we_width_plain: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(s_q.we_n) && !CFG_I.extended_wait_enable
    |-> $past(width_q) + 8'h01 == CFG_I.write_strobe_cycles)
    else $error("write strobe width wrong");
  a_oe_width_plain: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(s_q.oe_n) && !CFG_I.extended_wait_enable
    |-> $past(width_q) + 8'h01 == CFG_I.read_strobe_cycles)
    else $error("read strobe width wrong");
  a_wait_release: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    s_q.st == amst_pkg::ST_WAITX && !s_q.wait_s |-> ##3 (s_q.we_n && s_q.oe_n))
    else $error("strobe not released after wait dropped");
  a_addr_stable: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    s_q.busy && $past(s_q.busy) |-> $stable(EXT_ADDR_LINES_O) && $stable(BANK_SELECT_LINES_O))
    else $error("address moved during an access");
  a_data_driven: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    !s_q.we_n |-> !s_q.d_oe_n && $stable(EXT_DATA_LINES_O))
    else $error("write data not driven during strobe");
  a_wait_bound: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    s_q.st == amst_pkg::ST_WAITX |-> s_q.wcnt < CFG_I.max_ext_wait_cycles
      || CFG_I.max_ext_wait_cycles == 8'h00)
    else $error("wait count passed its limit");
endmodule : amst_engine
`default_nettype wire

/* verif/amst_mem_model.sv */
// Behavioural async memory holding wait while busy and returning read data
`timescale 1ns/10ps
`default_nettype none
module amst_mem_model (
  input wire logic clk_i,
  input wire logic [3:0] cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [31:0] wait_len_i,
  output logic wait_o = 1'b0,
  output logic [15:0] data_o = 16'h0000
);
  int cnt = 0;
  // Count strobe clocks; wait held until the busy time has run out
  always_ff @(posedge clk_i)
  begin
    if (cs_n_i == 4'hF)
      cnt <= 0;
    else if (!oe_n_i || !we_n_i)
      cnt <= cnt + 1;
    wait_o <= (cs_n_i != 4'hF) && (cnt < wait_len_i);
    // Read data only while selected and output enabled, else toggling junk
    data_o <= (!oe_n_i && cs_n_i != 4'hF) ? 16'h3C96 : ~data_o;
  end
endmodule : amst_mem_model
`default_nettype wire

/* verif/amst_engine_tb.sv */
// Testbench for the async memory strobe engine
`timescale 1ns/10ps
`default_nettype none
module amst_engine_tb;
  logic MCLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  amst_pkg::amst_cfg_s cfg = '0;
  amst_pkg::amst_req_s req = '0;
  logic vld = 1'b0;
  logic wt, we_n, oe_n, doe_n, busy, done, tmo;
  logic [15:0] md, dq, rd;
  logic [3:0] cs_n;
  logic [1:0] ba;
  logic [20:0] ad;
  logic [7:0] wcnt;
  logic [7:0] turn_v = 8'h00;
  int wl = 0;
  int n_mismatch = 0;
  int checks = 0;
  int lead, st, trail, dlead, gap, to_n, bad, bz, turn_n;
  // Clock generation
  initial
  begin
    forever #5 MCLK_I = ~MCLK_I;
  end
  amst_engine dut_u (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CFG_I(cfg), .REQ_VALID_I(vld),
    .REQ_I(req), .EXT_WAIT_INPUT_I(wt), .EXT_DATA_LINES_I(md),
    .MEMORY_CHIP_SELECT_N_O(cs_n), .ASYNC_WRITE_ENABLE_N_O(we_n),
    .ASYNC_OUTPUT_ENABLE_N_O(oe_n), .BANK_SELECT_LINES_O(ba), .EXT_ADDR_LINES_O(ad),
    .EXT_DATA_LINES_O(dq), .EXT_DATA_OE_N_O(doe_n), .BUSY_O(busy), .DONE_O(done),
    .TIMEOUT_O(tmo), .RDATA_O(rd), .EXT_WAIT_COUNT_O(wcnt));
  amst_mem_model mem_u (.clk_i(MCLK_I), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .wait_len_i(wl), .wait_o(wt), .data_o(md));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // One access; same setup, strobe, hold for read and write; pins profiled
  task automatic run(input logic w, input logic [7:0] s, t, h, input logic ss, xw,
    input logic [7:0] mx, input int wlen);
    logic sb;
    int k;
    lead = 0; st = 0; trail = 0; dlead = 0; gap = 0; to_n = 0; bad = 0; bz = 0;
    @(posedge MCLK_I);
    cfg <= '{turn_v, s, t, h, s, t, h, mx, xw, ss};
    req <= '{w, 4'h2, 2'h3, 21'h1ABCDE, 16'h5AA5};
    wl <= wlen;
    vld <= 1'b1;
    @(posedge MCLK_I);
    vld <= 1'b0;
    // Sample every cycle from the request edge on, until the done pulse
    for (k = 0; k < 2000; k++)
    begin
      #1;
      sb = w ? we_n : oe_n;
      if (cs_n != 4'hF && sb && st == 0) lead++;
      if (!doe_n && sb && st == 0) dlead++;
      if (!sb) st++;
      if (cs_n != 4'hF && sb && st > 0) trail++;
      if (!sb && !wt) gap++;
      if (tmo) to_n++;
      if (cs_n != 4'hF && (ba !== 2'h3 || ad !== 21'h1ABCDE || (w && dq !== 16'h5AA5))) bad++;
      if (busy === 1'b1) bz++;
      if (done === 1'b1) break;
      @(posedge MCLK_I);
    end
    if (k == 2000)
    begin
      n_mismatch++;
      finish_test();
    end
    $display("access done, mismatches %0d", n_mismatch);
  endtask : run
  // Main sequence
  initial
  begin
    logic [7:0] tab [3][3];
    tab = '{'{8'h02, 8'h03, 8'h01}, '{8'h00, 8'h01, 8'h00}, '{8'h05, 8'h01, 8'h04}};
    repeat (16) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    // Plain writes at several setup, strobe and hold lengths
    foreach (tab[i])
    begin
      run(1'b1, tab[i][0], tab[i][1], tab[i][2], 1'b0, 1'b0, 8'h00, 0);
      chk(lead, tab[i][0]);
      chk(st, tab[i][1]);
      chk(trail, tab[i][2]);
      chk(dlead, tab[i][0]);
      chk(bad, 0);
      chk(lead + st + trail, tab[i][0] + tab[i][1] + tab[i][2]);
      chk(bz, tab[i][0] + tab[i][1] + tab[i][2]);
    end
    // Select moves with strobe
    run(1'b1, 8'h02, 8'h03, 8'h01, 1'b1, 1'b0, 8'h00, 0);
    chk(lead, 0);
    chk(trail, 0);
    // Read without wait
    run(1'b0, 8'h01, 8'h04, 8'h02, 1'b0, 1'b0, 8'h00, 0);
    chk(st, 4);
    chk(lead + trail, 3);
    chk(rd, 16'h3C96);
    // Waited read and write; first low sample precedes the sampling edge
    run(1'b0, 8'h01, 8'h04, 8'h02, 1'b0, 1'b1, 8'hFF, 40);
    chk(gap, amst_pkg::WAIT_RELEASE_CYC + 1);
    chk(wcnt, 2);
    chk(to_n, 0);
    chk(rd, 16'h3C96);
    run(1'b1, 8'h02, 8'h03, 8'h01, 1'b0, 1'b1, 8'hFF, 40);
    chk(gap, amst_pkg::WAIT_RELEASE_CYC + 1);
    chk(wcnt, 2);
    chk(bad, 0);
    // Memory never ready: limit of one count ends the strobe
    run(1'b1, 8'h01, 8'h04, 8'h01, 1'b0, 1'b1, 8'h01, 300);
    chk(to_n, 1);
    chk(wcnt, 1);
    // Turnaround keeps the engine busy after the done pulse
    turn_v = 8'h03;
    run(1'b1, 8'h02, 8'h03, 8'h01, 1'b0, 1'b0, 8'h00, 0);
    for (turn_n = 0; turn_n < 20 && busy === 1'b1; turn_n++)
    begin
      @(posedge MCLK_I);
      #1;
    end
    chk(turn_n, 3);
    finish_test();
  end
endmodule : amst_engine_tb
`default_nettype wire
